/* jpsc_consts.svh */
// Register offsets, field positions, reset values and frame figures of the loop control bank.
`ifndef JPSC_CONSTS_SVH
`define JPSC_CONSTS_SVH

`define JPSC_OFF_VCO_DIV      7'h03
`define JPSC_OFF_SYNC_DIV     7'h07
`define JPSC_OFF_REF_DIV_OE   7'h0b
`define JPSC_OFF_FIRST_LOOP   7'h0d
`define JPSC_OFF_LOOP_OPTION  7'h10
`define JPSC_OFF_PULSE_COUNT  7'h17

`define JPSC_RST_VCO_DIV      8'h00
`define JPSC_RST_SYNC_DIV     8'h00
`define JPSC_RST_REF_DIV_OE   8'h0f
`define JPSC_RST_FIRST_LOOP   8'h20
`define JPSC_RST_LOOP_OPTION  8'h00
`define JPSC_RST_PULSE_COUNT  8'h00

`define JPSC_POS_POLARITY     7
`define JPSC_POS_HOLDOVER     6
`define JPSC_POS_BYPASS       4

`define JPSC_MASK_VCO_DIV     8'hfd
`define JPSC_MASK_SYNC_DIV    8'had
`define JPSC_MASK_LOOP_OPTION 8'hd0
`define JPSC_FIXED_LOOP_OPTION 8'h04

`define JPSC_HEAD_LAST        4'h7
`define JPSC_BODY_LAST        4'h7

`endif

/* jpsc_pkg.sv */
// Types shared by the serial port engine and the loop control register bank.
package jpsc_pkg;

    typedef enum logic [1:0] {
        JPSC_IDLE = 2'b00,
        JPSC_HEAD = 2'b01,
        JPSC_BODY = 2'b10,
        JPSC_END  = 2'b11
    } jpsc_state_t;

    typedef struct packed {
        logic       wr;
        logic [6:0] addr;
        logic [7:0] wdata;
    } jpsc_req_t;

endpackage

/* jpsc_spi_engine.sv */
// Serial configuration port engine: frames of one direction bit, seven address bits, one data byte.
`timescale 1ns/1ps
`default_nettype none
`include "jpsc_consts.svh"

module jpsc_spi_engine (
    input  wire logic          sys_clk_i,
    input  wire logic          rst_n_i,
    input  wire logic          spi_sclk_i,
    input  wire logic          spi_cs_n_i,
    input  wire logic          spi_sdi_i,
    input  wire logic [7:0]    rdata_i,
    output var  jpsc_pkg::jpsc_req_t req_o,
    output logic               spi_sdo_o,
    output logic               spi_sdo_oe_o
);
    import jpsc_pkg::*;

    jpsc_state_t st_ff,    nxt_st;
    logic        sclk_ff,  nxt_sclk;
    logic [3:0]  cnt_ff,   nxt_cnt;
    logic [7:0]  shin_ff,  nxt_shin;
    logic [7:0]  shout_ff, nxt_shout;
    logic        rd_ff,    nxt_rd;
    logic        sdo_ff,   nxt_sdo;
    logic        oe_ff,    nxt_oe;
    jpsc_req_t   req_ff,   nxt_req;
    logic        rise;
    logic        fall;
    logic [7:0]  shifted;

    assign rise    = spi_sclk_i & ~sclk_ff;
    assign fall    = ~spi_sclk_i & sclk_ff;
    assign shifted = {shin_ff[6:0], spi_sdi_i};

    always_comb begin
        nxt_st    = st_ff;
        nxt_sclk  = spi_sclk_i;
        nxt_cnt   = cnt_ff;
        nxt_shin  = shin_ff;
        nxt_shout = shout_ff;
        nxt_rd    = rd_ff;
        nxt_sdo   = sdo_ff;
        nxt_oe    = oe_ff;
        nxt_req   = req_ff;
        nxt_req.wr = 1'b0;
        if (spi_cs_n_i) begin
            nxt_st  = JPSC_IDLE;
            nxt_cnt = 4'h0;
            nxt_oe  = 1'b0;
        end else begin
            unique case (st_ff)
                JPSC_IDLE: begin
                    nxt_st  = JPSC_HEAD;
                    nxt_cnt = 4'h0;
                end
                JPSC_HEAD: begin
                    if (rise) begin
                        nxt_shin = shifted;
                        nxt_cnt  = cnt_ff + 4'h1;
                        if (cnt_ff == `JPSC_HEAD_LAST) begin
                            nxt_rd       = shifted[7];
                            nxt_req.addr = shifted[6:0];
                            nxt_cnt      = 4'h0;
                            nxt_st       = JPSC_BODY;
                        end
                    end
                end
                JPSC_BODY: begin
                    if (fall && rd_ff) begin
                        // The first falling edge of the data phase loads the read byte.
                        if (cnt_ff == 4'h0) begin
                            nxt_sdo   = rdata_i[7];
                            nxt_shout = {rdata_i[6:0], 1'b0};
                            nxt_oe    = 1'b1;
                        end else begin
                            nxt_sdo   = shout_ff[7];
                            nxt_shout = {shout_ff[6:0], 1'b0};
                        end
                    end
                    if (rise) begin
                        nxt_shin = shifted;
                        nxt_cnt  = cnt_ff + 4'h1;
                        if (cnt_ff == `JPSC_BODY_LAST) begin
                            nxt_req.wr    = ~rd_ff;
                            nxt_req.wdata = shifted;
                            nxt_st        = JPSC_END;
                        end
                    end
                end
                JPSC_END: begin
                    nxt_st = JPSC_END;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            st_ff    <= JPSC_IDLE;
            sclk_ff  <= 1'b0;
            cnt_ff   <= 4'h0;
            shin_ff  <= 8'h00;
            shout_ff <= 8'h00;
            rd_ff    <= 1'b0;
            sdo_ff   <= 1'b0;
            oe_ff    <= 1'b0;
            req_ff   <= '0;
        end else begin
            st_ff    <= nxt_st;
            sclk_ff  <= nxt_sclk;
            cnt_ff   <= nxt_cnt;
            shin_ff  <= nxt_shin;
            shout_ff <= nxt_shout;
            rd_ff    <= nxt_rd;
            sdo_ff   <= nxt_sdo;
            oe_ff    <= nxt_oe;
            req_ff   <= nxt_req;
        end
    end

    assign req_o        = req_ff;
    assign spi_sdo_o    = sdo_ff;
    assign spi_sdo_oe_o = oe_ff;

endmodule // jpsc_spi_engine

`default_nettype wire

/* jpsc_loop_regs.sv */
// Loop control and reference pulse register bank behind the serial configuration port.
`timescale 1ns/1ps
`default_nettype none
`include "jpsc_consts.svh"

module jpsc_loop_regs (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       spi_sclk_i,
    input  wire logic       spi_cs_n_i,
    input  wire logic       spi_sdi_i,
    output logic            spi_sdo_o,
    output logic            spi_sdo_oe_o,
    output logic [5:0]      pump_current_code_o,
    output logic            osc_tuning_polarity_o,
    output logic            holdover_o,
    output logic            tuning_park_mid_o,
    output logic            loop_bypass_o,
    output logic            loop_active_o,
    output logic [1:0]      clock_a_delay_o,
    output logic [7:0]      ref_pulse_count_field_o,
    output logic [3:0]      ref_divider_select_o,
    output logic            ref_out_a0_enable_o,
    output logic            ref_out_a1_enable_o,
    output logic            ref_out_b0_enable_o,
    output logic            ref_out_b1_enable_o,
    output logic            ref_output_trigger_o,
    output logic            vco_divider_powerdown_o,
    output logic [3:0]      vco_divider_ratio_o,
    output logic [3:0]      sync_divider_ratio_o,
    output logic            sync_divider_powerdown_o,
    output logic            request_flag_zero_o
);
    import jpsc_pkg::*;

    jpsc_req_t  req;
    logic [7:0] rdata;

    logic [7:0] vco_ff,   nxt_vco;
    logic [7:0] sync_ff,  nxt_sync;
    logic [7:0] refoe_ff, nxt_refoe;
    logic [7:0] loop_ff,  nxt_loop;
    logic [7:0] opt_ff,   nxt_opt;
    logic [7:0] cnt_ff,   nxt_cnt;
    logic       act_ff,   nxt_act;

    function automatic logic hit(input jpsc_req_t r, input logic [6:0] off);
        hit = r.wr && (r.addr == off);
    endfunction

    jpsc_spi_engine u_engine (
        .sys_clk_i    (sys_clk_i),
        .rst_n_i      (rst_n_i),
        .spi_sclk_i   (spi_sclk_i),
        .spi_cs_n_i   (spi_cs_n_i),
        .spi_sdi_i    (spi_sdi_i),
        .rdata_i      (rdata),
        .req_o        (req),
        .spi_sdo_o    (spi_sdo_o),
        .spi_sdo_oe_o (spi_sdo_oe_o)
    );

    always_comb begin
        nxt_vco   = vco_ff;
        nxt_sync  = sync_ff;
        nxt_refoe = refoe_ff;
        nxt_loop  = loop_ff;
        nxt_opt   = opt_ff;
        nxt_cnt   = cnt_ff;
        if (hit(req, `JPSC_OFF_VCO_DIV)) begin
            nxt_vco = req.wdata & `JPSC_MASK_VCO_DIV;
        end
        if (hit(req, `JPSC_OFF_SYNC_DIV)) begin
            nxt_sync = req.wdata & `JPSC_MASK_SYNC_DIV;
        end
        if (hit(req, `JPSC_OFF_REF_DIV_OE)) begin
            nxt_refoe = req.wdata;
        end
        if (hit(req, `JPSC_OFF_FIRST_LOOP)) begin
            nxt_loop = req.wdata;
        end
        if (hit(req, `JPSC_OFF_LOOP_OPTION)) begin
            nxt_opt = req.wdata & `JPSC_MASK_LOOP_OPTION;
        end
        if (hit(req, `JPSC_OFF_PULSE_COUNT)) begin
            nxt_cnt = req.wdata;
        end
        // The loop tracks only when neither held nor bypassed.
        nxt_act = ~nxt_loop[`JPSC_POS_HOLDOVER] & ~nxt_opt[`JPSC_POS_BYPASS];
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            vco_ff   <= `JPSC_RST_VCO_DIV;
            sync_ff  <= `JPSC_RST_SYNC_DIV;
            refoe_ff <= `JPSC_RST_REF_DIV_OE;
            loop_ff  <= `JPSC_RST_FIRST_LOOP;
            opt_ff   <= `JPSC_RST_LOOP_OPTION;
            cnt_ff   <= `JPSC_RST_PULSE_COUNT;
            act_ff   <= 1'b1;
        end else begin
            vco_ff   <= nxt_vco;
            sync_ff  <= nxt_sync;
            refoe_ff <= nxt_refoe;
            loop_ff  <= nxt_loop;
            opt_ff   <= nxt_opt;
            cnt_ff   <= nxt_cnt;
            act_ff   <= nxt_act;
        end
    end

    // Unmapped addresses and reserved bits read as zero; the loop option low bits read a fixed code.
    always_comb begin
        unique case (req.addr)
            `JPSC_OFF_VCO_DIV:     rdata = vco_ff;
            `JPSC_OFF_SYNC_DIV:    rdata = sync_ff;
            `JPSC_OFF_REF_DIV_OE:  rdata = refoe_ff;
            `JPSC_OFF_FIRST_LOOP:  rdata = loop_ff;
            `JPSC_OFF_LOOP_OPTION: rdata = opt_ff | `JPSC_FIXED_LOOP_OPTION;
            `JPSC_OFF_PULSE_COUNT: rdata = cnt_ff;
            default:               rdata = 8'h00;
        endcase
    end

    // The pump current equals this code times the unit step, so the code is driven unaltered.
    assign pump_current_code_o      = loop_ff[5:0];
    assign osc_tuning_polarity_o    = loop_ff[`JPSC_POS_POLARITY];
    assign holdover_o               = loop_ff[`JPSC_POS_HOLDOVER];
    assign tuning_park_mid_o        = loop_ff[`JPSC_POS_HOLDOVER];
    assign loop_bypass_o            = opt_ff[`JPSC_POS_BYPASS];
    assign loop_active_o            = act_ff;
    assign clock_a_delay_o          = opt_ff[7:6];
    assign ref_pulse_count_field_o  = cnt_ff;
    assign ref_divider_select_o     = refoe_ff[7:4];
    assign ref_out_b1_enable_o      = refoe_ff[3];
    assign ref_out_b0_enable_o      = refoe_ff[2];
    assign ref_out_a1_enable_o      = refoe_ff[1];
    assign ref_out_a0_enable_o      = refoe_ff[0];
    assign vco_divider_powerdown_o  = vco_ff[7];
    assign vco_divider_ratio_o      = vco_ff[6:3];
    assign ref_output_trigger_o     = vco_ff[0];
    assign request_flag_zero_o      = sync_ff[7];
    assign sync_divider_powerdown_o = sync_ff[5];
    assign sync_divider_ratio_o     = sync_ff[3:0];

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    pump_code_write_a: assert property (
        hit(req, `JPSC_OFF_FIRST_LOOP) |=> pump_current_code_o == $past(req.wdata[5:0]))
        else $error("Pump code did not follow a write.");
    pump_reset_a: assert property (
        $rose(rst_n_i) |-> pump_current_code_o == 6'h20)
        else $error("Pump code did not reset to 32.");
    polarity_write_a: assert property (
        hit(req, `JPSC_OFF_FIRST_LOOP) |=> osc_tuning_polarity_o == $past(req.wdata[7]))
        else $error("Polarity did not follow a write.");
    holdover_park_a: assert property (
        hit(req, `JPSC_OFF_FIRST_LOOP) |=> holdover_o == $past(req.wdata[6])
            && tuning_park_mid_o == holdover_o)
        else $error("Holdover or parking wrong after a write.");
    bypass_write_a: assert property (
        hit(req, `JPSC_OFF_LOOP_OPTION) |=> loop_bypass_o == $past(req.wdata[4]))
        else $error("Bypass did not follow a write.");
    loop_normal_a: assert property (
        loop_active_o == (!holdover_o && !loop_bypass_o))
        else $error("Loop activity disagrees with holdover and bypass.");
    pulse_count_a: assert property (
        !hit(req, `JPSC_OFF_PULSE_COUNT) |=> $stable(ref_pulse_count_field_o))
        else $error("Pulse count changed without a write.");
    reserved_read_a: assert property (
        req.addr == `JPSC_OFF_SYNC_DIV |-> rdata[6] == 1'b0 && rdata[4] == 1'b0)
        else $error("Reserved bits read nonzero.");

    holdover_cov_c: cover property (hit(req, `JPSC_OFF_FIRST_LOOP) ##1 holdover_o);
    bypass_cov_c:   cover property (hit(req, `JPSC_OFF_LOOP_OPTION) ##1 loop_bypass_o);
    read_cov_c:     cover property (spi_sdo_oe_o ##1 !spi_sdo_oe_o);
    count_cov_c:    cover property (hit(req, `JPSC_OFF_PULSE_COUNT) ##1 ref_pulse_count_field_o != 8'h00);

endmodule // jpsc_loop_regs

`default_nettype wire

/* jpsc_loop_regs_bench.sv */
// Self-checking bench of the loop control register bank, driven through its serial port.
`timescale 1ns/1ps
`default_nettype none
`include "jpsc_consts.svh"

module jpsc_loop_regs_bench;
    logic       sys_clk_i   = 1'b0;
    logic       rst_n_i     = 1'b0;
    logic       spi_sclk_i  = 1'b0;
    logic       spi_cs_n_i  = 1'b1;
    logic       spi_sdi_i   = 1'b0;
    logic       spi_sdo_o;
    logic       spi_sdo_oe_o;
    logic [5:0] pump_current_code_o;
    logic       osc_tuning_polarity_o;
    logic       holdover_o;
    logic       tuning_park_mid_o;
    logic       loop_bypass_o;
    logic       loop_active_o;
    logic [7:0] ref_pulse_count_field_o;
    logic [3:0] ref_divider_select_o;
    wire  [3:0] ref_oe;
    logic [1:0] clock_a_delay;
    logic       vco_pd;
    logic [3:0] vco_ratio;
    logic       vco_trig;
    logic       sync_pd;
    logic [3:0] sync_ratio;
    logic       flag_zero;
    logic [7:0] shadow [0:127];
    int         mismatches  = 0;
    int         compares    = 0;
    localparam logic [6:0] OFFS [6] = '{`JPSC_OFF_VCO_DIV, `JPSC_OFF_SYNC_DIV,
        `JPSC_OFF_REF_DIV_OE, `JPSC_OFF_FIRST_LOOP, `JPSC_OFF_LOOP_OPTION, `JPSC_OFF_PULSE_COUNT};
    localparam logic [7:0] CODES [6] = '{8'h45, 8'h3f, 8'h80, 8'h00, 8'h20, 8'hff};

    always #4 sys_clk_i = ~sys_clk_i;

    jpsc_loop_regs i_jpsc_loop_regs (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .spi_sclk_i(spi_sclk_i),
        .spi_cs_n_i(spi_cs_n_i), .spi_sdi_i(spi_sdi_i), .spi_sdo_o(spi_sdo_o),
        .spi_sdo_oe_o(spi_sdo_oe_o), .pump_current_code_o(pump_current_code_o),
        .osc_tuning_polarity_o(osc_tuning_polarity_o), .holdover_o(holdover_o),
        .tuning_park_mid_o(tuning_park_mid_o), .loop_bypass_o(loop_bypass_o),
        .loop_active_o(loop_active_o), .clock_a_delay_o(clock_a_delay),
        .ref_pulse_count_field_o(ref_pulse_count_field_o),
        .ref_divider_select_o(ref_divider_select_o), .ref_out_a0_enable_o(ref_oe[0]),
        .ref_out_a1_enable_o(ref_oe[1]), .ref_out_b0_enable_o(ref_oe[2]),
        .ref_out_b1_enable_o(ref_oe[3]), .ref_output_trigger_o(vco_trig),
        .vco_divider_powerdown_o(vco_pd), .vco_divider_ratio_o(vco_ratio),
        .sync_divider_ratio_o(sync_ratio), .sync_divider_powerdown_o(sync_pd),
        .request_flag_zero_o(flag_zero)
    );

    // Writable bits of each address; unmapped addresses keep nothing.
    function automatic logic [7:0] keep_mask(input logic [6:0] a);
        case (a)
            `JPSC_OFF_VCO_DIV:     return `JPSC_MASK_VCO_DIV;
            `JPSC_OFF_SYNC_DIV:    return `JPSC_MASK_SYNC_DIV;
            `JPSC_OFF_LOOP_OPTION: return `JPSC_MASK_LOOP_OPTION;
            `JPSC_OFF_REF_DIV_OE, `JPSC_OFF_FIRST_LOOP, `JPSC_OFF_PULSE_COUNT: return 8'hff;
            default:               return 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] fixed_bits(input logic [6:0] a);
        return (a == `JPSC_OFF_LOOP_OPTION) ? `JPSC_FIXED_LOOP_OPTION : 8'h00;
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic init_shadow;
        for (int i = 0; i < 128; i++) begin
            shadow[i] = 8'h00;
        end
        shadow[`JPSC_OFF_REF_DIV_OE] = `JPSC_RST_REF_DIV_OE;
        shadow[`JPSC_OFF_FIRST_LOOP] = `JPSC_RST_FIRST_LOOP;
        shadow[`JPSC_OFF_LOOP_OPTION] = `JPSC_RST_LOOP_OPTION | `JPSC_FIXED_LOOP_OPTION;
    endtask

    // Sends nbits of a frame MSB first; sdo is sampled as sclk rises in the data phase.
    task automatic frame(input logic [15:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        spi_cs_n_i <= 1'b0;
        for (int i = 15; i >= 16 - nbits; i--) begin
            spi_sclk_i <= 1'b0;
            spi_sdi_i  <= tx[i];
            tick(3);
            if (i < 8) begin
                rx[i] = spi_sdo_o;
                chk({7'h00, spi_sdo_oe_o}, {7'h00, tx[15]});
            end
            spi_sclk_i <= 1'b1;
            tick(3);
        end
        spi_cs_n_i <= 1'b1;
        spi_sclk_i <= 1'b0;
        tick(4);
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] rx;
        frame({1'b0, a, d}, 16, rx);
        shadow[a] = (d & keep_mask(a)) | fixed_bits(a);
    endtask

    task automatic rd(input logic [6:0] a);
        logic [7:0] rx;
        frame({1'b1, a, 8'h00}, 16, rx);
        chk(rx, shadow[a]);
    endtask

    task automatic check_outs;
        logic [7:0] lp;
        logic       byp;
        logic [7:0] vc;
        logic [7:0] sy;
        lp  = shadow[`JPSC_OFF_FIRST_LOOP];
        vc  = shadow[`JPSC_OFF_VCO_DIV];
        sy  = shadow[`JPSC_OFF_SYNC_DIV];
        byp = shadow[`JPSC_OFF_LOOP_OPTION][`JPSC_POS_BYPASS];
        chk({2'b00, pump_current_code_o}, {2'b00, lp[5:0]});
        chk({7'h00, osc_tuning_polarity_o}, {7'h00, lp[`JPSC_POS_POLARITY]});
        chk({6'h00, holdover_o, tuning_park_mid_o}, {6'h00, {2{lp[`JPSC_POS_HOLDOVER]}}});
        chk({7'h00, loop_bypass_o}, {7'h00, byp});
        chk({7'h00, loop_active_o}, {7'h00, !lp[`JPSC_POS_HOLDOVER] && !byp});
        chk(ref_pulse_count_field_o, shadow[`JPSC_OFF_PULSE_COUNT]);
        chk({ref_divider_select_o, ref_oe}, shadow[`JPSC_OFF_REF_DIV_OE]);
        chk({6'h00, clock_a_delay}, {6'h00, shadow[`JPSC_OFF_LOOP_OPTION][7:6]});
        chk({2'b00, vco_pd, vco_ratio, vco_trig}, {2'b00, vc[7:3], vc[0]});
        chk({2'b00, flag_zero, sync_pd, sync_ratio}, {2'b00, sy[7], sy[5], sy[3:0]});
    endtask

    task automatic reset_and_check;
        rst_n_i <= 1'b0;
        tick(8);
        rst_n_i <= 1'b1;
        init_shadow();
        check_outs();
        foreach (OFFS[i]) begin
            rd(OFFS[i]);
        end
        rd(7'h7f);
    endtask

    initial begin
        logic [7:0] rx;
        logic [6:0] a;
        rx = 8'($urandom(64226));
        reset_and_check();
        $display("test reset values done");
        foreach (CODES[i]) begin
            wr(`JPSC_OFF_FIRST_LOOP, CODES[i]);
            wr(`JPSC_OFF_LOOP_OPTION, ~CODES[i]);
            check_outs();
            rd(`JPSC_OFF_FIRST_LOOP);
            rd(`JPSC_OFF_LOOP_OPTION);
        end
        $display("test loop corner codes done");
        frame({1'b0, `JPSC_OFF_PULSE_COUNT, 8'haa}, 10, rx);
        check_outs();
        rd(`JPSC_OFF_PULSE_COUNT);
        $display("test abandoned frame done");
        repeat (30) begin
            a = ($urandom % 3 != 0) ? OFFS[$urandom % 6] : 7'($urandom);
            wr(a, 8'($urandom));
            check_outs();
            rd(a);
        end
        $display("test random accesses done");
        reset_and_check();
        $display("test second reset done");
        stop_test();
    end

    initial begin
        tick(50000);
        mismatches++;
        stop_test();
    end
endmodule // jpsc_loop_regs_bench
`default_nettype wire
